// [verilog/lcd_ctrl_pkg.sv]
// package: register map, field layout, reset values and timing for lcd control
package lcd_ctrl_pkg;
	localparam int ADDR_W = 16;
	localparam int DATA_W = 4;
	localparam int MEM_WORDS = 48;
	localparam int MEM_IDX_W = 6;
	localparam int COM_W = 6;
	localparam int SEG_CNT_W = 8;
	localparam int CONTRAST_W = 4;
	localparam logic [15:0] OFF_DRIVE_CTRL = 16'hff60;
	localparam logic [15:0] OFF_OVERRIDE = 16'hff61;
	localparam logic [15:0] OFF_CONTRAST = 16'hff62;
	localparam logic [15:0] OFF_DISP_MEM = 16'hf000;
	// drive control fields
	localparam int BIT_SUPPLY_ON = 0;
	localparam int BIT_DRIVE_METHOD = 1;
	localparam int BIT_DUTY_LOW = 2;
	localparam int BIT_DUTY_HIGH = 3;
	// override fields
	localparam int BIT_ALL_ON = 1;
	localparam int BIT_ALL_OFF = 2;
	// reset values
	localparam logic [3:0] RST_DRIVE_CTRL = 4'h0;
	localparam logic [3:0] RST_OVERRIDE = 4'h4;
	localparam logic [3:0] RST_CONTRAST = 4'h0;
	// supply settle time, kept for software reference
	localparam int SUPPLY_SETTLE_MS = 100;
	localparam int CLK_HZ = 40000000;
	localparam longint SUPPLY_SETTLE_CYC = longint'(SUPPLY_SETTLE_MS) *
		longint'(CLK_HZ) / 1000;
	typedef enum logic [1:0] {
		DUTY_1_4 = 2'b00,
		DUTY_1_5 = 2'b01,
		DUTY_1_6 = 2'b10,
		DUTY_1_3 = 2'b11
	} duty_t;
endpackage

// [verilog/lcd_bus_if.sv]
// interface: cpu access path from the top module to the display memory
`timescale 1ns/100ps
interface lcd_bus_if;
	logic wr;
	logic [5:0] idx;
	logic [3:0] wdata;
	logic [3:0] rdata;
	modport ctrl (output wr, output idx, output wdata, input rdata);
	modport mem (input wr, input idx, input wdata, output rdata);
endinterface

// [verilog/lcd_disp_mem.sv]
// display memory: 48 words of 4 bits in flip-flops, index addressed
`timescale 1ns/100ps
module lcd_disp_mem (
	// clock
	input wire logic clk,
	// cpu port
	lcd_bus_if.mem bus,
	// scan read port
	input wire logic [5:0] scan_idx,
	output logic [3:0] scan_data
);
	import lcd_ctrl_pkg::*;
	logic [3:0] mem_r [MEM_WORDS];

	// no reset: content is undefined until software fills it
	always_ff @(posedge clk) begin
		if (bus.wr && bus.idx < MEM_IDX_W'(MEM_WORDS)) begin
			mem_r[bus.idx] <= bus.wdata;
		end
	end

	// out-of-range words read as zero
	assign bus.rdata = (bus.idx < MEM_IDX_W'(MEM_WORDS)) ?
		mem_r[bus.idx] : 4'h0;
	assign scan_data = (scan_idx < MEM_IDX_W'(MEM_WORDS)) ?
		mem_r[scan_idx] : 4'h0;
endmodule

// [verilog/lcd_driver_control.sv]
// lcd driver control: registers, display memory access and drive settings
// usage notes
// - the block holds settings only; segment and common waveforms are built
//   elsewhere from the outputs below
// - the supply settle wait is left to software; nothing here delays the
//   drive outputs after the supply bit is set
// - display memory has no reset, so the scan port shows unknown data until
//   software has written every word in use
// - the all-off bit comes out of reset set, so the panel stays blank until
//   software clears it and turns the supply on
// - a write and a read in the same cycle both act; the read returns the
//   value held before that edge
// - dc-configured segment pins are never reported as grounded, whatever the
//   supply bit says
`timescale 1ns/100ps
module lcd_driver_control (
	// clock and reset
	input wire logic REF_CLK,
	input wire logic RESETN,
	// cpu bus
	input wire logic [lcd_ctrl_pkg::ADDR_W-1:0] ADDR,
	input wire logic [lcd_ctrl_pkg::DATA_W-1:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [lcd_ctrl_pkg::DATA_W-1:0] RDATA,
	// build option: lcd voltage supplied from outside
	input wire logic EXT_SUPPLY,
	// segment dc-output configuration, one bit per segment pin
	input wire logic [31:0] SEG_DC_CFG,
	// display scan
	input wire logic [5:0] SCAN_IDX,
	output logic [3:0] SCAN_DATA,
	// drive settings
	output logic SUPPLY_EN,
	output logic VDRIVE_GROUND,
	output logic [31:0] SEG_SUPPLY_GATED,
	output logic [1:0] DUTY_SEL,
	output logic [lcd_ctrl_pkg::COM_W-1:0] COMMON_LINES_EN,
	output logic [lcd_ctrl_pkg::SEG_CNT_W-1:0] SEG_MAX,
	output logic STATIC_DRIVE,
	output logic SEG_FORCE_ON,
	output logic SEG_FORCE_OFF,
	output logic [lcd_ctrl_pkg::CONTRAST_W-1:0] CONTRAST_CODE
);
	import lcd_ctrl_pkg::*;

	logic [3:0] drive_ctrl_r;
	logic [3:0] override_r;
	logic [3:0] contrast_r;
	logic [3:0] rdata_r;
	logic sel_drive, sel_ovr, sel_con, sel_mem;
	duty_t duty;
	lcd_bus_if bus ();
	// bits that exist in the override register; the rest read zero
	localparam logic [3:0] ovr_keep = 4'((4'h1 << BIT_ALL_ON) |
		(4'h1 << BIT_ALL_OFF));

	////////////////////////////////////////////////////////////////////////
	// address decode

	// number of commons used for a duty code
	function automatic logic [2:0] commons_of(input duty_t d);
		unique case (d)
			DUTY_1_3: commons_of = 3'd3;
			DUTY_1_6: commons_of = 3'd6;
			DUTY_1_5: commons_of = 3'd5;
			DUTY_1_4: commons_of = 3'd4;
		endcase
	endfunction

	// full 16-bit compare, so no alias of a register appears elsewhere
	function automatic logic hit(input logic [15:0] a,
		input logic [15:0] off);
		hit = (a == off);
	endfunction

	// memory window check, shared by the select and any later reuse
	function automatic logic in_mem(input logic [15:0] a);
		in_mem = (a >= OFF_DISP_MEM) &&
			(a < OFF_DISP_MEM + 16'(MEM_WORDS));
	endfunction

	assign sel_drive = hit(ADDR, OFF_DRIVE_CTRL);
	assign sel_ovr = hit(ADDR, OFF_OVERRIDE);
	assign sel_con = hit(ADDR, OFF_CONTRAST);
	// memory window covers 48 words from f000
	assign sel_mem = in_mem(ADDR);
	assign bus.wr = WR && sel_mem;
	assign bus.idx = 6'(ADDR - OFF_DISP_MEM);
	assign bus.wdata = WDATA;

	lcd_disp_mem u_mem (
		.clk(REF_CLK),
		.bus(bus),
		.scan_idx(SCAN_IDX),
		.scan_data(SCAN_DATA)
	);

	////////////////////////////////////////////////////////////////////////
	// control registers

	// drive control: all four bits implemented
	always_ff @(posedge REF_CLK or negedge RESETN) begin
		if (!RESETN) begin
			drive_ctrl_r <= RST_DRIVE_CTRL;
		end else if (WR && sel_drive) begin
			drive_ctrl_r <= WDATA;
		end
	end

	// override: only d1 and d2 exist, others held at zero
	always_ff @(posedge REF_CLK or negedge RESETN) begin
		if (!RESETN) begin
			override_r <= RST_OVERRIDE;
		end else if (WR && sel_ovr) begin
			override_r <= WDATA & ovr_keep;
		end
	end

	// contrast code
	always_ff @(posedge REF_CLK or negedge RESETN) begin
		if (!RESETN) begin
			contrast_r <= RST_CONTRAST;
		end else if (WR && sel_con) begin
			contrast_r <= WDATA;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read path: one nibble registered per read, unmapped reads zero

	always_ff @(posedge REF_CLK or negedge RESETN) begin
		if (!RESETN) begin
			rdata_r <= 4'h0;
		end else if (RD) begin
			if (sel_drive) begin
				rdata_r <= drive_ctrl_r;
			end else if (sel_ovr) begin
				rdata_r <= override_r & ovr_keep;
			end else if (sel_con) begin
				rdata_r <= contrast_r;
			end else if (sel_mem) begin
				rdata_r <= bus.rdata;
			end else begin
				rdata_r <= 4'h0;
			end
		end
	end
	assign RDATA = rdata_r;

	////////////////////////////////////////////////////////////////////////
	// drive settings

	// supply on or all drive voltages at ground
	assign SUPPLY_EN = drive_ctrl_r[BIT_SUPPLY_ON];
	assign VDRIVE_GROUND = ~drive_ctrl_r[BIT_SUPPLY_ON];
	// dc-configured pins keep their own level regardless of supply
	assign SEG_SUPPLY_GATED = VDRIVE_GROUND ? ~SEG_DC_CFG : 32'h0;

	assign duty = duty_t'({drive_ctrl_r[BIT_DUTY_HIGH],
		drive_ctrl_r[BIT_DUTY_LOW]});
	assign DUTY_SEL = duty;
	// thermometer mask of the commons in use
	assign COMMON_LINES_EN = 6'((7'h1 << commons_of(duty)) - 7'h1);
	// 32 segments per common
	assign SEG_MAX = {commons_of(duty), 5'h0};
	assign STATIC_DRIVE = drive_ctrl_r[BIT_DRIVE_METHOD];

	// all-on overrides all-off; memory itself is untouched
	assign SEG_FORCE_ON = override_r[BIT_ALL_ON];
	// off is masked by on rather than the reverse, so a panel test with
	// both bits set still lights everything
	assign SEG_FORCE_OFF = override_r[BIT_ALL_OFF] &
		~override_r[BIT_ALL_ON];

	// external supply makes the code meaningless, so it is held at lightest
	assign CONTRAST_CODE = EXT_SUPPLY ? 4'h0 : contrast_r;
endmodule

// [tb/lcd_panel_model.sv]
// model: panel that reports how many common rows are driven
`timescale 1ns/100ps
module lcd_panel_model (
	// common enables from the block
	input wire logic [5:0] com_en,
	// rows the panel scans
	output logic [2:0] n_com
);
	// a gap in the enables is not counted, so gaps show up as a size error
	assign n_com = 3'($countones(com_en));
endmodule

// [tb/lcd_driver_control_chk.sv]
// checker: port relations of the lcd control block
`timescale 1ns/100ps
module lcd_driver_control_chk (
	// clock, reset, bus
	input wire logic REF_CLK,
	input wire logic RESETN,
	input wire logic [15:0] ADDR,
	input wire logic [3:0] WDATA,
	input wire logic WR,
	// options
	input wire logic EXT_SUPPLY,
	input wire logic [31:0] SEG_DC_CFG,
	// settings
	input wire logic SUPPLY_EN,
	input wire logic VDRIVE_GROUND,
	input wire logic [31:0] SEG_SUPPLY_GATED,
	input wire logic [5:0] COMMON_LINES_EN,
	input wire logic [7:0] SEG_MAX,
	input wire logic STATIC_DRIVE,
	input wire logic SEG_FORCE_ON,
	input wire logic SEG_FORCE_OFF,
	input wire logic [3:0] CONTRAST_CODE
);
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (!RESETN);
	////////////////////
	property p_gnd; VDRIVE_GROUND != SUPPLY_EN; endproperty
	a_gnd: assert property (p_gnd) else $error("clamp");
	property p_dc; (SEG_SUPPLY_GATED & SEG_DC_CFG) == 32'h0; endproperty
	a_dc: assert property (p_dc) else $error("dc gated");
	property p_seg; SEG_MAX == 8'(32 * $countones(COMMON_LINES_EN)); endproperty
	a_seg: assert property (p_seg) else $error("seg max");
	property p_drv; WR && ADDR == 16'hff60 |=>
		STATIC_DRIVE == $past(WDATA[1]); endproperty
	a_drv: assert property (p_drv) else $error("method");
	property p_on; WR && ADDR == 16'hff61 |=>
		SEG_FORCE_ON == $past(WDATA[1]); endproperty
	a_on: assert property (p_on) else $error("all on");
	property p_off; WR && ADDR == 16'hff61 |=>
		SEG_FORCE_OFF == ($past(WDATA[2]) && !$past(WDATA[1]));
	endproperty
	a_off: assert property (p_off) else $error("all off");
	property p_win; SEG_FORCE_ON |-> !SEG_FORCE_OFF; endproperty
	a_win: assert property (p_win) else $error("priority");
	property p_ext; EXT_SUPPLY |-> CONTRAST_CODE == 4'h0; endproperty
	a_ext: assert property (p_ext) else $error("ext");
	property p_rst; $rose(RESETN) |-> SEG_FORCE_OFF && !SUPPLY_EN; endproperty
	a_rst: assert property (p_rst) else $error("reset");
	// main scenarios reached
	c_on: cover property (SEG_FORCE_ON);
	c_ext: cover property (EXT_SUPPLY);
	c_dc: cover property (!SUPPLY_EN && SEG_DC_CFG != 32'h0);
endmodule
bind lcd_driver_control lcd_driver_control_chk u_chk (.*);

// [tb/lcd_driver_control_test.sv]
// testbench: lcd control registers, duty decode and memory
`timescale 1ns/100ps
`define CHK(n, e, a) begin n_tests++; if ((a) !== (e)) begin \
$display("MISMATCH %s exp %h got %h", n, e, a); bad_count++; end end
module lcd_driver_control_test;
	typedef struct {logic [3:0] w; logic [5:0] c; logic [7:0] m;} row_t;
	// control word, expected commons, expected segment count
	row_t rows [5] = '{'{4'h1, 6'h0f, 8'h80}, '{4'h7, 6'h1f, 8'ha0},
		'{4'hb, 6'h3f, 8'hc0}, '{4'hd, 6'h07, 8'h60}, '{4'hc, 6'h07, 8'h60}};
	logic [3:0] ov [4] = '{4'hf, 4'h4, 4'h2, 4'h0};
	logic clk, resetn, wr, rd, ext, sup, vgnd, stat, f_on, f_off;
	logic [15:0] addr;
	logic [3:0] wdata, rdata, scan_d, lvl;
	logic [5:0] scan, com_en;
	logic [7:0] seg_max;
	logic [1:0] dsel;
	logic [31:0] seg_dc, gated;
	logic [2:0] n_com;
	int bad_count = 0;
	int n_tests = 0;
	lcd_driver_control u_lcd_driver_control (.REF_CLK(clk), .RESETN(resetn),
		.ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
		.EXT_SUPPLY(ext), .SEG_DC_CFG(seg_dc), .SCAN_IDX(scan),
		.SCAN_DATA(scan_d), .SUPPLY_EN(sup), .VDRIVE_GROUND(vgnd),
		.SEG_SUPPLY_GATED(gated), .DUTY_SEL(dsel), .COMMON_LINES_EN(com_en),
		.SEG_MAX(seg_max), .STATIC_DRIVE(stat), .SEG_FORCE_ON(f_on),
		.SEG_FORCE_OFF(f_off), .CONTRAST_CODE(lvl));
	lcd_panel_model u_lcd_panel_model (.com_en(com_en), .n_com(n_com));
	////////////////////
	// 40 mhz clock
	initial begin
		clk = 0;
		forever #12.5 clk = ~clk;
	end
	// one nibble, 2 ns after an edge; an idle cycle follows so that the
	// strobes are never lowered and raised again in one time step
	task acc(input logic w, input logic [15:0] a, input logic [3:0] d);
		addr = a;
		wdata = d;
		wr = w;
		rd = !w;
		@(posedge clk);
		#2;
		wr = 0;
		rd = 0;
		@(posedge clk);
		#2;
	endtask
	task report_and_stop;
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	// whole run is under 100 accesses, so 200 us means a hang
	initial begin
		#200000;
		bad_count++;
		report_and_stop();
	end
	////////////////////
	initial begin
		resetn = 0;
		addr = 16'h0;
		wdata = 4'h0;
		wr = 0;
		rd = 0;
		ext = 0;
		seg_dc = 32'h5555aaaa;
		scan = 6'h0;
		repeat (6) @(posedge clk);
		#2;
		resetn = 1;
		acc(0, 16'hff61, 4'h0);
		`CHK("ovr", 4'h4, rdata)
		acc(0, 16'hff62, 4'h0);
		`CHK("lvl", 4'h0, rdata)
		$display("reset done");
		foreach (rows[i]) begin
			acc(1, 16'hff60, rows[i].w); // no analog wait needed
			acc(0, 16'hff60, 4'h0);
			`CHK("rd", rows[i].w, rdata)
			`CHK("com", rows[i].c, com_en)
			`CHK("pnl", rows[i].m, {n_com, 5'h0})
			`CHK("stat", rows[i].w[1], stat)
			`CHK("gnd", !rows[i].w[0], vgnd)
			`CHK("sup", rows[i].w[0], sup)
			`CHK("dsel", rows[i].w[3:2], dsel)
		end
		`CHK("dc", ~seg_dc, gated)
		$display("duty done");
		acc(1, 16'hf000, 4'ha); // software fills memory
		acc(1, 16'hf02f, 4'h5);
		foreach (ov[i]) begin
			acc(1, 16'hff61, ov[i]);
			acc(0, 16'hff61, 4'h0);
			`CHK("ovr", ov[i] & 4'h6, rdata)
			`CHK("off", ov[i][2] & !ov[i][1], f_off)
			`CHK("on", ov[i][1], f_on)
		end
		acc(0, 16'hf000, 4'h0);
		`CHK("m0", 4'ha, rdata)
		scan = 6'h2f;
		acc(0, 16'hf030, 4'h0);
		`CHK("m30", 4'h0, rdata)
		`CHK("scan", 4'h5, scan_d)
		$display("memory done");
		acc(1, 16'hff62, 4'hf);
		`CHK("dark", 4'hf, lvl)
		ext = 1;
		acc(0, 16'hff62, 4'h0);
		`CHK("ext", 4'h0, lvl)
		$display("contrast done");
		report_and_stop();
	end
endmodule
